// File: oaq_pkg.sv
// Constants, types and layouts for the overcurrent alert qualifier.
// Assumes a 200 MHz system clock and a 12-bit sense sample stream.
//
// Behaviour
// - Free-running 10 us window, no external phase
// - Averaged input judged at each window end
// - Shortest delay: one exceeding window asserts alert
// - Non-exceeding window leaves alert high
// - Medium delay: five consecutive exceeding windows
// - Failing window resets consecutive counter
// - Longest delay: ten consecutive exceeding windows
// - Delay pin: float 10, ground 50, supply 100
// - Latency varies up to one window
// - Medium adds 40 us, longest adds 90
// - Hysteresis pin: float 2, ground 4, supply 8 mV
// - Alert is active-low open drain
// - Release after one window below threshold minus hysteresis; LATCH high holds alert until disable
// - Disable clears counter, restart from zero
package oaq_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int    CLK_MHZ      = 200;
    localparam int    WINDOW_US    = 10;
    localparam int    WIN_CYC_INT  = WINDOW_US * CLK_MHZ;
    localparam [10:0] WIN_CYCLES   = 11'(WIN_CYC_INT);
    localparam int    DELAY_S_US   = 10;
    localparam int    DELAY_M_US   = 50;
    localparam int    DELAY_L_US   = 100;
    localparam [3:0]  WIN_SHORT    = 4'(DELAY_S_US / WINDOW_US);
    localparam [3:0]  WIN_MEDIUM   = 4'(DELAY_M_US / WINDOW_US);
    localparam [3:0]  WIN_LONG     = 4'(DELAY_L_US / WINDOW_US);

    // ****************************************
    // Sample scale and hysteresis
    // ****************************************
    localparam int    SAMPLE_W     = 12;
    localparam int    ACC_W        = 23;
    localparam int    LSB_NV       = 62500;
    localparam int    HYS_S_UV     = 2000;
    localparam int    HYS_M_UV     = 4000;
    localparam int    HYS_L_UV     = 8000;
    localparam [11:0] HYS_S_CODE   = 12'(HYS_S_UV * 1000 / LSB_NV);
    localparam [11:0] HYS_M_CODE   = 12'(HYS_M_UV * 1000 / LSB_NV);
    localparam [11:0] HYS_L_CODE   = 12'(HYS_L_UV * 1000 / LSB_NV);

    // ****************************************
    // Register map
    // ****************************************
    localparam [11:0] ADDR_THRESH  = 12'h000;
    localparam [11:0] ADDR_STATUS  = 12'h004;
    localparam [11:0] ADDR_INT_ST  = 12'h008;
    localparam [11:0] ADDR_INT_MSK = 12'h00c;
    localparam [11:0] THRESH_RST   = 12'hfff;
    localparam [2:0]  INT_MSK_RST  = 3'h0;
    localparam int    ST_ALERT     = 0;
    localparam int    ST_CNT_LSB   = 1;
    localparam int    ST_DLY_LSB   = 5;
    localparam int    ST_HYS_LSB   = 7;
    localparam int    ST_EN        = 9;
    localparam int    ST_LATCH     = 10;
    localparam int    EV_ASSERT    = 0;
    localparam int    EV_RELEASE   = 1;
    localparam int    EV_FAIL      = 2;
    localparam int    EV_N         = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        OAQ_LVL_FLOAT  = 2'b00,
        OAQ_LVL_GND    = 2'b01,
        OAQ_LVL_SUPPLY = 2'b10
    } oaq_lvl_e;

    typedef enum logic [0:0] {
        OAQ_IDLE  = 1'b0,
        OAQ_ALERT = 1'b1
    } oaq_state_e;

    typedef struct packed {
        logic win_end;
        logic over;
        logic below;
    } oaq_win_s;

endpackage : oaq_pkg

// File: oaq_window.sv
// Free-running comparison window with sample averaging.
// Assumes samples arrive each cycle from front-end logic on the same clock.
`timescale 1ns/100ps
module oaq_window
    import oaq_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [SAMPLE_W-1:0] thresh,
    input  wire logic [SAMPLE_W-1:0] hyst,
    output oaq_win_s                 res
);

    logic [10:0]      win_cnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] total;
    logic [ACC_W-1:0] hi_lim;
    logic [ACC_W-1:0] lo_lim;
    logic [SAMPLE_W-1:0] lo_thr;
    logic             last;

    // ****************************************
    // Window timer
    // ****************************************
    assign last = (win_cnt == WIN_CYCLES - 11'h001);

    always_ff @(posedge clk) begin
        if (reset) begin
            win_cnt <= 11'h000;
        end else if (ce) begin
            win_cnt <= last ? 11'h000 : win_cnt + 11'h001;
        end
    end

    // ****************************************
    // Sum over window, compare at its end
    // ****************************************
    assign total  = acc + ACC_W'(sample);
    assign lo_thr = (thresh > hyst) ? thresh - hyst : 12'h000;
    assign hi_lim = ACC_W'(thresh) * ACC_W'(WIN_CYCLES);
    assign lo_lim = ACC_W'(lo_thr) * ACC_W'(WIN_CYCLES);

    always_ff @(posedge clk) begin
        if (reset) begin
            acc <= '0;
        end else if (ce) begin
            acc <= last ? '0 : total;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            res <= '0;
        end else if (ce) begin
            res.win_end <= last;
            res.over    <= last && (total > hi_lim);
            res.below   <= last && (total < lo_lim);
        end
    end

endmodule : oaq_window

// File: oaq_top.sv
// Overcurrent alert qualifier: window counting, alert pin and APB registers.
// Assumes level-detect pads deliver 2-bit codes for the delay and
// hysteresis pins, asynchronous to CLK_SYS, and an external pull-up.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module oaq_top
    import oaq_pkg::*;
(
    input  wire logic                CLK_SYS,
    input  wire logic                RESET,
    input  wire logic                CE,
    input  wire logic [SAMPLE_W-1:0] SENSE_SAMPLE,
    input  wire logic [1:0]          DELAY_LVL,
    input  wire logic [1:0]          HYSTERESIS_SELECT,
    input  wire logic                ENABLE,
    input  wire logic                LATCH,
    output logic                     ALERT_O,
    output logic                     ALERT_OE_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    input  wire logic [3:0]          PSTRB,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    output logic                     IRQ
);

    logic [1:0]          dly_m;
    logic [1:0]          dly_s;
    logic [1:0]          hys_m;
    logic [1:0]          hys_s;
    logic [1:0]          en_m;
    logic [1:0]          latch_m;
    logic                en_s;
    logic                latch_s;
    logic [3:0]          target;
    logic [SAMPLE_W-1:0] hyst_code;
    logic [SAMPLE_W-1:0] thresh;
    oaq_win_s            win;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    oaq_state_e          state;
    oaq_state_e          next_state;
    logic [EV_N-1:0]     ev;
    logic [EV_N-1:0]     int_st;
    logic [EV_N-1:0]     int_msk;
    logic                acc_en;
    logic                rd_st;
    logic                mapped;
    logic [31:0]         rd_val;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            dly_m   <= 2'h0;
            dly_s   <= 2'h0;
            hys_m   <= 2'h0;
            hys_s   <= 2'h0;
            en_m    <= 2'h0;
            latch_m <= 2'h0;
        end else if (CE) begin
            dly_m   <= DELAY_LVL;
            dly_s   <= dly_m;
            hys_m   <= HYSTERESIS_SELECT;
            hys_s   <= hys_m;
            en_m    <= {en_m[0], ENABLE};
            latch_m <= {latch_m[0], LATCH};
        end
    end

    assign en_s    = en_m[1];
    assign latch_s = latch_m[1];

    // ****************************************
    // Three-level pin decode
    // ****************************************
    always_comb begin
        case (oaq_lvl_e'(dly_s))
            OAQ_LVL_FLOAT:  target = WIN_SHORT;
            OAQ_LVL_GND:    target = WIN_MEDIUM;
            OAQ_LVL_SUPPLY: target = WIN_LONG;
            default:        target = WIN_SHORT;
        endcase
    end

    always_comb begin
        case (oaq_lvl_e'(hys_s))
            OAQ_LVL_FLOAT:  hyst_code = HYS_S_CODE;
            OAQ_LVL_GND:    hyst_code = HYS_M_CODE;
            OAQ_LVL_SUPPLY: hyst_code = HYS_L_CODE;
            default:        hyst_code = HYS_S_CODE;
        endcase
    end

    // ****************************************
    // Comparison window
    // ****************************************
    oaq_window u_window (
        .clk    (CLK_SYS),
        .reset  (RESET),
        .ce     (CE),
        .sample (SENSE_SAMPLE),
        .thresh (thresh),
        .hyst   (hyst_code),
        .res    (win)
    );

    // ****************************************
    // Consecutive-window counter
    // ****************************************
    always_comb begin
        next_cnt = cnt;
        if (!en_s) begin
            next_cnt = 4'h0;
        end else if (win.win_end) begin
            if (!win.over) begin
                next_cnt = 4'h0;
            end else if (cnt < target) begin
                next_cnt = cnt + 4'h1;
            end else begin
                next_cnt = target;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cnt <= 4'h0;
        end else if (CE) begin
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // Alert state
    // ****************************************
    always_comb begin
        next_state = state;
        case (state)
            OAQ_IDLE: begin
                if (en_s && win.win_end && win.over && next_cnt >= target) begin
                    next_state = OAQ_ALERT;
                end
            end
            OAQ_ALERT: begin
                if (!en_s) begin
                    next_state = OAQ_IDLE;
                end else if (win.win_end && win.below && !latch_s) begin
                    next_state = OAQ_IDLE;
                end
            end
            default: next_state = OAQ_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= OAQ_IDLE;
        end else if (CE) begin
            state <= next_state;
        end
    end

    // Pin always pulls to ground; enable alone decides
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ALERT_O    <= 1'b0;
            ALERT_OE_N <= 1'b1;
        end else if (CE) begin
            ALERT_O    <= 1'b0;
            ALERT_OE_N <= (next_state != OAQ_ALERT);
        end
    end

    // ****************************************
    // Events and interrupt
    // ****************************************
    assign ev[EV_ASSERT]  = (state == OAQ_IDLE)  && (next_state == OAQ_ALERT);
    assign ev[EV_RELEASE] = (state == OAQ_ALERT) && (next_state == OAQ_IDLE);
    assign ev[EV_FAIL]    = en_s && win.win_end && !win.over && (cnt != 4'h0);

    assign acc_en = PSEL && PENABLE && PREADY;
    assign rd_st  = acc_en && !PWRITE && (PADDR == ADDR_INT_ST);

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            int_st <= '0;
        end else if (CE) begin
            int_st <= (rd_st ? '0 : int_st) | ev;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(((rd_st ? '0 : int_st) | ev) & int_msk);
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (PADDR)
            ADDR_THRESH:  rd_val[SAMPLE_W-1:0] = thresh;
            ADDR_STATUS: begin
                rd_val[ST_ALERT]                = (state == OAQ_ALERT);
                rd_val[ST_CNT_LSB +: 4]         = cnt;
                rd_val[ST_DLY_LSB +: 2]         = dly_s;
                rd_val[ST_HYS_LSB +: 2]         = hys_s;
                rd_val[ST_EN]                   = en_s;
                rd_val[ST_LATCH]                = latch_s;
            end
            ADDR_INT_ST:  rd_val[EV_N-1:0] = int_st;
            ADDR_INT_MSK: rd_val[EV_N-1:0] = int_msk;
            default:      mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= PSEL && !PENABLE && !PREADY;
            PSLVERR <= PSEL && !PENABLE && !PREADY && !mapped;
            if (PSEL && !PENABLE && !PREADY && !PWRITE) begin
                PRDATA <= rd_val;
            end
        end
    end

    // Threshold may change at any time, new value used at once
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            thresh  <= THRESH_RST;
            int_msk <= INT_MSK_RST;
        end else if (CE && acc_en && PWRITE) begin
            if (PADDR == ADDR_THRESH) begin
                if (PSTRB[0]) thresh[7:0]  <= PWDATA[7:0];
                if (PSTRB[1]) thresh[11:8] <= PWDATA[11:8];
            end
            if (PADDR == ADDR_INT_MSK && PSTRB[0]) begin
                int_msk <= PWDATA[EV_N-1:0];
            end
        end
    end

endmodule : oaq_top

// File: oaq_top_props.sv
// Checker: alert pin, window phase and APB handshake of the qualifier.
// Assumes it is bound to oaq_top and sees only that module's ports.
`timescale 1ns/100ps
module oaq_top_props
    import oaq_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic CE,
    input wire logic ENABLE,
    input wire logic ALERT_O,
    input wire logic ALERT_OE_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    logic [10:0] phase;
    logic [10:0] ph_ref;
    logic        ph_seen;
    logic [11:0] hi_cnt;

    // ****************
    // Helper counters
    // ****************
    always_ff @(posedge CLK_SYS) begin
        if (RESET)
            phase <= 11'h000;
        else if (CE)
            phase <= (phase == WIN_CYCLES - 11'h001) ? 11'h000 : phase + 11'h001;
    end

    // Phase of the first assertion, later ones must match it
    always_ff @(posedge CLK_SYS) begin
        if (RESET)
            ph_seen <= 1'b0;
        else if ($fell(ALERT_OE_N) && !ph_seen) begin
            ph_seen <= 1'b1;
            ph_ref  <= phase;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET || !ALERT_OE_N)
            hi_cnt <= 12'h000;
        else if (hi_cnt != 12'hfff)
            hi_cnt <= hi_cnt + 12'h001;
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    AST_OD_DATA: assert property (ALERT_O == 1'b0)
        else $error("alert data line not low");
    AST_WIN_PHASE: assert property ($fell(ALERT_OE_N) && ph_seen |-> phase == ph_ref)
        else $error("alert asserted off the window grid");
    AST_MIN_HIGH: assert property ($fell(ALERT_OE_N) |-> hi_cnt >= 12'h7ce)
        else $error("alert asserted before a full window");
    AST_DISABLE_REL: assert property (!ENABLE [*5] |-> ALERT_OE_N)
        else $error("alert held while disabled");
    AST_RESET_STATE: assert property (disable iff (1'b0) RESET |=> ALERT_OE_N && !IRQ && !PREADY)
        else $error("outputs wrong after reset");
    AST_APB_READY: assert property (PSEL && !PENABLE && !PREADY && CE |=> PREADY)
        else $error("no ready in access cycle");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error outside access cycle");
endmodule : oaq_top_props

bind oaq_top oaq_top_props props_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .ENABLE(ENABLE),
    .ALERT_O(ALERT_O), .ALERT_OE_N(ALERT_OE_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));

// File: oaq_ctrl_model.sv
// System controller model: APB master for the registers, pulled-up alert line.
// Assumes APB sampled on the rising edge of clk.
`timescale 1ns/100ps
module oaq_ctrl_model
    import oaq_pkg::*;
(
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        alert_o,
    input  wire logic        alert_oe_n,
    output logic             alert_n
);
    // 500 uV noise term in sample codes
    localparam logic [11:0] NOISE_CODES = 12'(500000 / LSB_NV);

    assign alert_n = (alert_oe_n === 1'b0) ? alert_o : 1'b1;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // ****************
    // Bus transfer
    // ****************
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic ok);
        ok = 1'b0;
        r  = 32'h0;
        e  = 1'b0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                r  = prdata;
                e  = pslverr;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer

    task automatic set_trip(input logic [11:0] trip, input logic shortest, output logic ok);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, ADDR_THRESH, {20'h0, trip + (shortest ? NOISE_CODES : 12'h000)}, r, e, ok);
    endtask : set_trip
endmodule : oaq_ctrl_model

// File: oaq_top_test.sv
// Self-checking bench: delay settings, hysteresis, restarts and registers.
// Assumes oaq_top, its checker and the controller model in the same compile.
`timescale 1ns/100ps
module oaq_top_test;
    import oaq_pkg::*;
    typedef struct {
        oaq_lvl_e    dly;
        oaq_lvl_e    hysteresis_select;
        int          n;
        logic [11:0] hc;
    } oaq_row_s;
    localparam logic [11:0] TRIP = 12'h400;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        enable  = 1'b1;
    logic [11:0] sense   = 12'h000;
    oaq_lvl_e    dly     = OAQ_LVL_FLOAT;
    oaq_lvl_e    hysteresis_select     = OAQ_LVL_FLOAT;
    logic [11:0] th;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        psel, penable, pwrite, pready, pslverr, alert_o, alert_oe_n, alert_n, irq, err, ok;
    int          n_mismatch  = 0;
    int          check_count = 0;
    int          cyc;
    oaq_row_s    rows [3];

    always #2.5 clk_sys = ~clk_sys;

    oaq_top dut_u (.CLK_SYS(clk_sys), .RESET(reset), .CE(1'b1), .SENSE_SAMPLE(sense), .DELAY_LVL(dly),
        .HYSTERESIS_SELECT(hysteresis_select), .ENABLE(enable), .LATCH(1'b0), .ALERT_O(alert_o), .ALERT_OE_N(alert_oe_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    oaq_ctrl_model ctrl_u (.clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alert_o(alert_o),
        .alert_oe_n(alert_oe_n), .alert_n(alert_n));

    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic c, input string m);
        check_count++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk

    task automatic bus_ok;
        chk(ok, "bus transfer timed out");
        if (ok !== 1'b1) wrap_up();
    endtask : bus_ok

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
        ctrl_u.xfer(1'b0, a, 32'h0, rd, err, ok);
        bus_ok();
        chk(!err && rd === x, "register read");
    endtask : rd_chk

    task automatic wait_lvl(input logic l, input int lim);
        cyc = -1;
        for (int i = 0; i < lim && cyc < 0; i++) begin
            @(posedge clk_sys);
            if (alert_n === l) cyc = i;
        end
    endtask : wait_lvl

    task automatic expect_lvl(input logic l, input int lo, input int hi);
        wait_lvl(l, hi + 1);
        chk(cyc >= lo, "alert timing");
        if (cyc < 0) wrap_up();
    endtask : expect_lvl

    task automatic wrap_up;
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ****************
    // Sequence
    // ****************
    initial begin
        rows = '{'{OAQ_LVL_FLOAT, OAQ_LVL_FLOAT, 1, HYS_S_CODE}, '{OAQ_LVL_GND, OAQ_LVL_SUPPLY, 5, HYS_L_CODE},
                 '{OAQ_LVL_SUPPLY, OAQ_LVL_GND, 10, HYS_M_CODE}};
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(alert_n === 1'b1 && irq === 1'b0, "reset outputs");
        rd_chk(ADDR_THRESH, 32'h0000_0fff);
        rd_chk(ADDR_INT_MSK, 32'h0);
        ctrl_u.xfer(1'b0, 12'h010, 32'h0, rd, err, ok);
        bus_ok();
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        ctrl_u.xfer(1'b1, ADDR_INT_MSK, 32'h1, rd, err, ok);
        bus_ok();
        foreach (rows[i]) begin
            dly <= rows[i].dly;
            hysteresis_select <= rows[i].hysteresis_select;
            th = TRIP + ((rows[i].n == 1) ? 12'h008 : 12'h000);
            ctrl_u.set_trip(TRIP, rows[i].n == 1, ok);
            bus_ok();
            sense <= th + 12'h001;
            expect_lvl(1'b0, rows[i].n * 2000, rows[i].n * 2000 + 2004);
            sense <= th - rows[i].hc;
            wait_lvl(1'b1, 4008);
            chk(cyc < 0, "released inside hysteresis");
            sense <= th - rows[i].hc - 12'h001;
            // Phase known from the assertion edge: release lands one window later
            expect_lvl(1'b1, 1900, 2004);
            sense <= 12'h000;
            if (rows[i].n == 1) begin
                chk(irq === 1'b1, "interrupt on assertion");
                ctrl_u.xfer(1'b0, ADDR_INT_ST, 32'h0, rd, err, ok);
                bus_ok();
                chk(rd[1:0] === 2'b11, "event status");
                repeat (3) @(posedge clk_sys);
                chk(irq === 1'b0, "interrupt after read clear");
            end
        end
        dly <= OAQ_LVL_GND;
        ctrl_u.set_trip(TRIP, 1'b0, ok);
        bus_ok();
        for (int b = 0; b < 2; b++) begin
            sense <= TRIP + 12'h001;
            wait_lvl(1'b0, 5000);
            chk(cyc < 0, "alert before five windows");
            if (b == 0)
                sense <= 12'h000;
            else
                enable <= 1'b0;
            repeat (20) @(posedge clk_sys);
            sense  <= TRIP + 12'h001;
            enable <= 1'b1;
            expect_lvl(1'b0, 8000, 12010);
            enable <= 1'b0;
            expect_lvl(1'b1, 0, 6);
            repeat (20) @(posedge clk_sys);
            enable <= 1'b1;
        end
        wrap_up();
    end
endmodule : oaq_top_test
